/* cac_regs.vh */
// Register map, field positions and codes for the counter action control block
`ifndef CAC_REGS_VH
`define CAC_REGS_VH

// ==========================================================================
// Register word addresses (byte address = 4 * word index)
`define CAC_ADDR_W          4
`define CAC_REG_CONFIG      4'h0
`define CAC_REG_CODE        4'h1
`define CAC_REG_VALUE       4'h2
`define CAC_REG_UPDATE      4'h3
`define CAC_REG_COUNT       4'h4
`define CAC_REG_OFFSET      4'h5
`define CAC_REG_STATUS      4'h6
`define CAC_REG_DOWNLOAD    4'h7
`define CAC_REG_ENCPOS      4'h8

// ==========================================================================
// CONFIG fields
`define CAC_CFG_SSI         0
`define CAC_CFG_ABS         1
`define CAC_CFG_MULTI_LSB   8
`define CAC_CFG_MULTI_MSB   12
`define CAC_CFG_SINGLE_LSB  16
`define CAC_CFG_SINGLE_MSB  20
`define CAC_CFG_RESET       32'h00000000

// ==========================================================================
// STATUS fields
`define CAC_STAT_IDX_LSB    0
`define CAC_STAT_M1         16
`define CAC_STAT_M2         17
`define CAC_STAT_REJECT     18
`define CAC_STAT_ABSMODE    19

// ==========================================================================
// UPDATE / DOWNLOAD trigger bit
`define CAC_TRIG_BIT        0

// ==========================================================================
// Action codes
`define CAC_ACT_W           3
`define CAC_ACT_KEEP        3'h0
`define CAC_ACT_LOAD        3'h1
`define CAC_ACT_OFFSET      3'h2
`define CAC_ACT_SHIFT       3'h3
`define CAC_ACT_RESET       3'h4
`define CAC_ACT_RESET_OUT   3'h5
`define CAC_ACT_PRESET      3'h6
`define CAC_ACT_PRESET_OUT  3'h7

// ==========================================================================
// Reset values
`define CAC_ZERO32          32'h00000000
`define CAC_BITLEN_W        6

`endif

/* cac_action_decode.v */
// Action code decoder with range checks for offset and position requests
`default_nettype none
`include "cac_regs.vh"

module cac_action_decode
(
    // Request
    input  wire [`CAC_ACT_W-1:0]    action_code,
    input  wire signed [31:0]       action_value,
    // Configuration
    input  wire                     abs_ssi,
    input  wire [`CAC_BITLEN_W-1:0] bit_len,
    // Effects
    output reg                      load_count,
    output reg                      load_zero,
    output reg                      set_offset,
    output reg                      shift_pos,
    output reg                      clr_compare,
    output reg                      cmp_out_off,
    output reg                      tbl_out_off,
    output reg                      reject
);

    // ==========================================================================
    // Range helpers, 64-bit so a 31-bit length cannot overflow
    wire signed [63:0] val_wide;
    wire signed [63:0] limit;

    assign val_wide = {{32{action_value[31]}}, action_value};
    assign limit    = $signed(64'h1 << bit_len);

    always @*
    begin
        load_count  = 1'b0;
        load_zero   = 1'b0;
        set_offset  = 1'b0;
        shift_pos   = 1'b0;
        clr_compare = 1'b0;
        cmp_out_off = 1'b0;
        tbl_out_off = 1'b0;
        reject      = 1'b0;
        case (action_code)
            `CAC_ACT_KEEP:
                reject = 1'b0;
            `CAC_ACT_LOAD:
                if (abs_ssi)
                    reject = 1'b1;
                else
                    load_count = 1'b1;
            `CAC_ACT_OFFSET:
                if (abs_ssi)
                begin
                    if (val_wide > -limit && val_wide < limit)
                        set_offset = 1'b1;
                    else
                        reject = 1'b1;
                end
            `CAC_ACT_SHIFT:
                if (abs_ssi)
                begin
                    if (val_wide > 64'sh0 && val_wide < limit)
                        shift_pos = 1'b1;
                    else
                        reject = 1'b1;
                end
            `CAC_ACT_RESET, `CAC_ACT_RESET_OUT:
            begin
                load_zero   = ~abs_ssi;
                clr_compare = 1'b1;
                cmp_out_off = action_code[0];
            end
            `CAC_ACT_PRESET, `CAC_ACT_PRESET_OUT:
            begin
                load_count  = ~abs_ssi;
                clr_compare = 1'b1;
                cmp_out_off = action_code[0];
                tbl_out_off = action_code[0];
            end
            default:
                reject = 1'b0;
        endcase
    end

endmodule // cac_action_decode

`default_nettype wire

/* cac_counter_action.v */
// Counter channel driven by action codes, with Avalon-MM register access
// ==========================================================================
// Behaviour
// - Code zero changes nothing in count, configuration or compare state.
// - In ring form code one loads the count with the action value; in absolute form it is rejected.
// - In absolute form code two stores an offset and count is encoder position plus offset.
// - An offset outside the open range of plus or minus two to the bit length is rejected.
// - In ring form code two is ignored.
// - Downloading the configuration again clears the offset to zero.
// - In absolute form code three shifts so count equals value, range zero to 2^len open.
// - In ring form code three does nothing; code one is used instead.
// - Code four clears count, the table compare index and both match flags.
// - With an absolute encoder code four keeps the count but still clears compare state.
// - Code five does what four does and switches the compare outputs off.
// - Code six loads the count and clears the table index and both match flags.
// - With an absolute encoder code six keeps the count but still clears compare state.
// - Code seven does what six does and switches table and compare outputs off.
//
// Local design decisions: the Avalon-MM slave port and the address map.
`default_nettype none
`include "cac_regs.vh"

module cac_counter_action
#(
    parameter IDX_W = 16
)
(
    // Clock and reset
    input  wire                     clk,
    input  wire                     rst,
    // Avalon-MM slave
    input  wire [`CAC_ADDR_W-1:0]   avs_address,
    input  wire                     avs_read,
    input  wire                     avs_write,
    input  wire [31:0]              avs_writedata,
    input  wire [3:0]               avs_byteenable,
    output reg  [31:0]              avs_readdata,
    output reg                      avs_waitrequest,
    // Counting sources
    input  wire                     count_up,
    input  wire                     count_down,
    input  wire [31:0]              encoder_position,
    // Compare engine events
    input  wire                     match_one_hit,
    input  wire                     match_two_hit,
    input  wire                     table_advance,
    // Counter and compare state
    output reg  [31:0]              current_count,
    output reg  [IDX_W-1:0]         table_compare_index,
    output reg                      match_flag_one,
    output reg                      match_flag_two,
    output reg                      compare_out_off,
    output reg                      table_out_off
);

    // ==========================================================================
    // Register state
    reg  [31:0]              config_q;
    reg  [`CAC_ACT_W-1:0]    code_q;
    reg  signed [31:0]       value_q;
    reg  signed [31:0]       offset_q;
    reg  [31:0]              count_q;
    reg                      reject_q;

    wire                     access;
    wire                     wr_go;
    wire                     rd_go;
    wire                     update_go;
    wire                     download_go;
    wire                     abs_ssi;
    wire [`CAC_BITLEN_W-1:0] bit_len;
    wire [31:0]              wdata_merged;
    wire [31:0]              status_word;

    wire dec_load;
    wire dec_zero;
    wire dec_offset;
    wire dec_shift;
    wire dec_clear;
    wire dec_cmp_off;
    wire dec_tbl_off;
    wire dec_reject;

    // Merge write data with byte enables over the current contents
    function [31:0] merge_bytes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  be;
        integer      i;
        begin
            merge_bytes = old_word;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
        end
    endfunction

    // ==========================================================================
    // Bus handshake: one wait cycle, then the request completes
    assign access      = avs_read | avs_write;
    assign wr_go       = avs_write & ~avs_waitrequest;
    assign rd_go       = avs_read & avs_waitrequest;
    assign update_go   = wr_go && avs_address == `CAC_REG_UPDATE
                         && avs_byteenable[0] && avs_writedata[`CAC_TRIG_BIT];
    assign download_go = wr_go && avs_address == `CAC_REG_DOWNLOAD
                         && avs_byteenable[0] && avs_writedata[`CAC_TRIG_BIT];

    assign abs_ssi      = config_q[`CAC_CFG_SSI] & config_q[`CAC_CFG_ABS];
    assign bit_len      = {1'b0, config_q[`CAC_CFG_MULTI_MSB:`CAC_CFG_MULTI_LSB]}
                        + {1'b0, config_q[`CAC_CFG_SINGLE_MSB:`CAC_CFG_SINGLE_LSB]};
    assign wdata_merged = merge_bytes(config_q, avs_writedata, avs_byteenable);

    assign status_word = {12'h000,
                          abs_ssi,
                          reject_q,
                          match_flag_two,
                          match_flag_one,
                          {(16-IDX_W){1'b0}},
                          table_compare_index};

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~(access & avs_waitrequest);
    end

    // ==========================================================================
    // Action decode
    cac_action_decode u_decode
    (
        .action_code  (code_q),
        .action_value (value_q),
        .abs_ssi      (abs_ssi),
        .bit_len      (bit_len),
        .load_count   (dec_load),
        .load_zero    (dec_zero),
        .set_offset   (dec_offset),
        .shift_pos    (dec_shift),
        .clr_compare  (dec_clear),
        .cmp_out_off  (dec_cmp_off),
        .tbl_out_off  (dec_tbl_off),
        .reject       (dec_reject)
    );

    // ==========================================================================
    // Software registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            config_q <= `CAC_CFG_RESET;
            code_q   <= `CAC_ACT_KEEP;
            value_q  <= `CAC_ZERO32;
        end
        else if (wr_go)
        begin
            case (avs_address)
                `CAC_REG_CONFIG:
                    config_q <= wdata_merged;
                `CAC_REG_CODE:
                    if (avs_byteenable[0])
                        code_q <= avs_writedata[`CAC_ACT_W-1:0];
                `CAC_REG_VALUE:
                    value_q <= merge_bytes(value_q, avs_writedata, avs_byteenable);
                default:
                    code_q <= code_q;
            endcase
        end
    end

    // ==========================================================================
    // Offset: set, shifted, or cleared by a fresh configuration download
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            offset_q <= `CAC_ZERO32;
        else if (download_go || (wr_go && avs_address == `CAC_REG_CONFIG
                                 && !wdata_merged[`CAC_CFG_ABS]))
            offset_q <= `CAC_ZERO32;
        else if (update_go && dec_offset)
            offset_q <= value_q;
        else if (update_go && dec_shift)
            offset_q <= value_q - $signed(encoder_position);
    end

    // ==========================================================================
    // Counter: counts pulses in both forms; loads and clears take effect in ring form only
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            count_q <= `CAC_ZERO32;
        else if (update_go && dec_zero)
            count_q <= `CAC_ZERO32;
        else if (update_go && dec_load)
            count_q <= value_q;
        else if (count_up && !count_down)
            count_q <= count_q + 32'h00000001;
        else if (count_down && !count_up)
            count_q <= count_q - 32'h00000001;
    end

    // Absolute form shows position plus offset; a shift takes hold at once
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            current_count <= `CAC_ZERO32;
        else if (abs_ssi && update_go && dec_shift)
            current_count <= value_q;
        else if (abs_ssi && update_go && dec_offset)
            current_count <= encoder_position + value_q;
        else if (abs_ssi)
            current_count <= encoder_position + offset_q;
        else if (update_go && dec_zero)
            current_count <= `CAC_ZERO32;
        else if (update_go && dec_load)
            current_count <= value_q;
        else if (count_up && !count_down)
            current_count <= count_q + 32'h00000001;
        else if (count_down && !count_up)
            current_count <= count_q - 32'h00000001;
        else
            current_count <= count_q;
    end

    // ==========================================================================
    // Compare state: a clear restarts the table at its first entry
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            table_compare_index <= {IDX_W{1'b0}};
        else if (update_go && dec_clear)
            table_compare_index <= {IDX_W{1'b0}};
        else if (table_advance)
            table_compare_index <= table_compare_index + {{(IDX_W-1){1'b0}}, 1'b1};
    end

    // A hit in the clearing cycle is kept so no match is lost
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            match_flag_one <= 1'b0;
            match_flag_two <= 1'b0;
        end
        else
        begin
            match_flag_one <= match_one_hit | (match_flag_one & ~(update_go & dec_clear));
            match_flag_two <= match_two_hit | (match_flag_two & ~(update_go & dec_clear));
        end
    end

    // Output-off strobes last one cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            compare_out_off <= 1'b0;
            table_out_off   <= 1'b0;
        end
        else
        begin
            compare_out_off <= update_go & dec_cmp_off;
            table_out_off   <= update_go & dec_tbl_off;
        end
    end

    // Reject flag reflects the most recent update
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            reject_q <= 1'b0;
        else if (update_go)
            reject_q <= dec_reject;
    end

    // ==========================================================================
    // Read data, registered on the wait cycle; unmapped words read zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= `CAC_ZERO32;
        else if (rd_go)
        begin
            case (avs_address)
                `CAC_REG_CONFIG:  avs_readdata <= config_q;
                `CAC_REG_CODE:    avs_readdata <= {29'h0000000, code_q};
                `CAC_REG_VALUE:   avs_readdata <= value_q;
                `CAC_REG_COUNT:   avs_readdata <= current_count;
                `CAC_REG_OFFSET:  avs_readdata <= offset_q;
                `CAC_REG_STATUS:  avs_readdata <= status_word;
                `CAC_REG_ENCPOS:  avs_readdata <= encoder_position;
                default:          avs_readdata <= `CAC_ZERO32;
            endcase
        end
    end

endmodule // cac_counter_action

`default_nettype wire

/* cac_counter_action_sva.sv */
// Port checker for the counter action control block
`default_nettype none
`include "cac_regs.vh"

module cac_counter_action_sva
#(
    parameter IDX_W = 16
)
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // Bus
    input wire logic [`CAC_ADDR_W-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_writedata,
    input wire logic                   avs_waitrequest,
    // Sources
    input wire logic                   count_up,
    input wire logic                   count_down,
    input wire logic                   match_one_hit,
    input wire logic                   match_two_hit,
    // State
    input wire logic [31:0]            current_count,
    input wire logic [IDX_W-1:0]       table_compare_index,
    input wire logic                   match_flag_one,
    input wire logic                   match_flag_two,
    input wire logic                   compare_out_off,
    input wire logic                   table_out_off
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Shadow of code, value and form; assumes full-word writes
    logic [2:0]  code_q;
    logic [31:0] val_q;
    logic        abs_q;
    logic        wr_ok;
    logic        upd;
    logic        quiet;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign upd   = wr_ok && avs_address == `CAC_REG_UPDATE && avs_writedata[`CAC_TRIG_BIT];
    assign quiet = upd && !abs_q && !count_up && !count_down;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            code_q <= 3'h0;
            val_q  <= 32'h0;
            abs_q  <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (avs_address == `CAC_REG_CODE)
                code_q <= avs_writedata[2:0];
            if (avs_address == `CAC_REG_VALUE)
                val_q <= avs_writedata;
            if (avs_address == `CAC_REG_CONFIG)
                abs_q <= avs_writedata[`CAC_CFG_SSI] & avs_writedata[`CAC_CFG_ABS];
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmp_pulse;
        compare_out_off ##1 !compare_out_off;
    endsequence
    sequence s_tbl_pulse;
        table_out_off ##1 !table_out_off;
    endsequence
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("waitrequest stayed high");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_idx_clear: assert property (upd && code_q[2] |=> table_compare_index == '0)
        else $error("table index not cleared");
    chk_flag_clear: assert property (upd && code_q[2] && !match_one_hit && !match_two_hit
        |=> !match_flag_one && !match_flag_two) else $error("match flags not cleared");
    chk_cmp_pulse: assert property (upd && code_q[2] && code_q[0] |=> s_cmp_pulse)
        else $error("compare off pulse wrong");
    chk_tbl_pulse: assert property (upd && code_q == `CAC_ACT_PRESET_OUT |=> s_tbl_pulse)
        else $error("table off pulse wrong");
    chk_no_pulse: assert property (!(upd && code_q[2] && code_q[0]) |=> !compare_out_off)
        else $error("stray compare off pulse");
    chk_load_count: assert property (quiet
        && (code_q == 3'h1 || code_q[2:1] == 2'h3) |=> current_count == $past(val_q))
        else $error("load wrong");
    chk_zero_count: assert property (quiet && code_q[2:1] == 2'h2 |=> current_count == 32'h0)
        else $error("count not cleared");
    chk_keep_count: assert property (quiet && (code_q == 3'h0 || code_q[2:1] == 2'h1)
        |=> $stable(current_count)) else $error("count changed");
endmodule // cac_counter_action_sva
`default_nettype wire

/* cac_host.sv */
// Bus master model standing in for the controlling program
`default_nettype none
`include "cac_regs.vh"

module cac_host
(
    // Clock
    input  wire logic                   clk,
    // Avalon-MM master
    output var logic [`CAC_ADDR_W-1:0]  avs_address,
    output var logic                    avs_read,
    output var logic                    avs_write,
    output var logic [31:0]             avs_writedata,
    output var logic [3:0]              avs_byteenable,
    input  wire logic [31:0]            avs_readdata,
    input  wire logic                   avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end
    // ====================
    // One request held until waitrequest is seen low; one idle edge after
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
endmodule // cac_host
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the counter action control block
`default_nettype none
`include "cac_regs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst, count_up, count_down, match_one_hit, match_two_hit, table_advance;
    logic [3:0] avs_address, avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, compare_out_off, table_out_off;
    logic [31:0] avs_writedata, avs_readdata, encoder_position, current_count, rdat;
    logic [15:0] table_compare_index;
    logic match_flag_one, match_flag_two;
    int mismatches = 0, samples_checked = 0, cycles = 0, n_cmp = 0, n_tbl = 0;

    always #12.5 clk = ~clk;

    cac_counter_action i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .count_up(count_up), .count_down(count_down),
        .encoder_position(encoder_position), .match_one_hit(match_one_hit),
        .match_two_hit(match_two_hit), .table_advance(table_advance),
        .current_count(current_count), .table_compare_index(table_compare_index),
        .match_flag_one(match_flag_one), .match_flag_two(match_flag_two),
        .compare_out_off(compare_out_off), .table_out_off(table_out_off));
    cac_host i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ====================
    // Helpers
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_host.xfer(1'b0, a, d, rdat);
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        i_host.xfer(1'b1, a, 32'h0, rdat);
        chk(what, exp, rdat);
    endtask
    // Extra edge lets the one-cycle off pulses reach the pulse counters
    task automatic act(input logic [2:0] c, input logic [31:0] v);
        wr(`CAC_REG_CODE, {29'h0, c});
        wr(`CAC_REG_VALUE, v);
        wr(`CAC_REG_UPDATE, 32'h1);
        @(posedge clk);
    endtask
    task automatic bump(input logic up, input int n);
        count_up   <= up;
        count_down <= !up;
        repeat (n) @(posedge clk);
        count_up   <= 1'b0;
        count_down <= 1'b0;
        @(posedge clk);
    endtask
    task automatic arm;
        table_advance <= 1'b1;
        match_one_hit <= 1'b1;
        match_two_hit <= 1'b1;
        repeat (2) @(posedge clk);
        table_advance <= 1'b0;
        match_one_hit <= 1'b0;
        match_two_hit <= 1'b0;
        @(posedge clk);
        chk("armed index", 32'h2, 32'(table_compare_index));
    endtask

    // ====================
    // Scenarios
    task automatic t_reset;
        rd_chk("count", `CAC_REG_COUNT, 32'h0);
        rd_chk("code", `CAC_REG_CODE, 32'h0);
        rd_chk("status", `CAC_REG_STATUS, 32'h0);
        rd_chk("unmapped", 4'hF, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_ring;
        bump(1'b1, 3);
        bump(1'b0, 1);
        chk("counted", 32'h2, current_count);
        act(`CAC_ACT_KEEP, 32'h55);
        chk("keep", 32'h2, current_count);
        act(`CAC_ACT_LOAD, 32'hFFFFFFFB);
        chk("load", 32'hFFFFFFFB, current_count);
        act(`CAC_ACT_OFFSET, 32'h7);
        chk("ring offset", 32'hFFFFFFFB, current_count);
        rd_chk("offset", `CAC_REG_OFFSET, 32'h0);
        act(`CAC_ACT_SHIFT, 32'h9);
        chk("ring shift", 32'hFFFFFFFB, current_count);
        $display("ring test done");
    endtask
    task automatic t_clear;
        for (int c = 4; c < 8; c++)
        begin
            arm();
            n_cmp = 0;
            n_tbl = 0;
            act(3'(c), 32'h64);
            chk("index", 32'h0, 32'(table_compare_index));
            chk("flags", 32'h0, {30'h0, match_flag_one, match_flag_two});
            chk("count", (c >= 6) ? 32'h64 : 32'h0, current_count);
            chk("cmp off", 32'(c % 2), 32'(n_cmp));
            chk("tbl off", 32'(c == 7), 32'(n_tbl));
        end
        $display("clear test done");
    endtask
    task automatic t_abs;
        wr(`CAC_REG_CONFIG, 32'h00080403);
        act(`CAC_ACT_OFFSET, 32'h32);
        chk("abs offset", 32'h41A, current_count);
        act(`CAC_ACT_OFFSET, 32'h1000);
        rd_chk("big offset", `CAC_REG_OFFSET, 32'h32);
        rd_chk("reject", `CAC_REG_STATUS, 32'h000C0000);
        act(`CAC_ACT_OFFSET, 32'hFFFFF001);
        chk("edge offset", 32'hFFFFF3E9, current_count);
        act(`CAC_ACT_SHIFT, 32'h0);
        chk("zero shift", 32'hFFFFF3E9, current_count);
        act(`CAC_ACT_SHIFT, 32'h7D0);
        chk("shift", 32'h7D0, current_count);
        arm();
        act(`CAC_ACT_RESET, 32'h0);
        chk("abs reset", 32'h7D0, current_count);
        chk("abs index", 32'h0, 32'(table_compare_index));
        arm();
        act(`CAC_ACT_PRESET, 32'h5);
        chk("abs preset", 32'h7D0, current_count);
        chk("abs flags", 32'h0, {30'h0, match_flag_one, match_flag_two});
        wr(`CAC_REG_DOWNLOAD, 32'h1);
        rd_chk("download", `CAC_REG_OFFSET, 32'h0);
        chk("raw count", 32'h3E8, current_count);
        encoder_position <= 32'h3F0;
        repeat (2) @(posedge clk);
        chk("follow", 32'h3F0, current_count);
        $display("absolute test done");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (compare_out_off === 1'b1)
            n_cmp++;
        if (table_out_off === 1'b1)
            n_tbl++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        {count_up, count_down, match_one_hit, match_two_hit, table_advance} = 5'h0;
        encoder_position = 32'h3E8;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_ring();
        t_clear();
        t_abs();
        give_verdict();
    end
endmodule // testbench

bind cac_counter_action cac_counter_action_sva #(.IDX_W(IDX_W)) i_sva (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .count_up(count_up),
    .count_down(count_down), .match_one_hit(match_one_hit), .match_two_hit(match_two_hit),
    .current_count(current_count), .table_compare_index(table_compare_index),
    .match_flag_one(match_flag_one), .match_flag_two(match_flag_two),
    .compare_out_off(compare_out_off), .table_out_off(table_out_off));
`default_nettype wire
